// *** src/dcrw_regs.sv ***
// dcrw_regs: accumulators, alternates, product and multiplier input
// with their transfer and operand widths.
// assumes: one request per cycle from the decoder on sys_clk.
//
// Functional notes
// RULE1: serial control, serial address and tdm control are write-only.
// RULE2: alternate accumulators reached only by the swap instruction.
// RULE3: accumulators hold 36 bits; product and multiplier input 32.
// RULE4: accumulator moves are 16 bits; copies and load from mult 36.
// RULE5: arithmetic is 36 bits except high increment and immediate forms.
// RULE6: product moves upper half; multiply/ALU to accumulator uses 32.
// RULE7: mult input moves upper half; special function to accum uses 32.
// RULE8: mult input is a 32-bit operand except in the plain multiply.
// RULE9: product or mult input sign-extends to 36 bits with accumulators.
// RULE10: immediate alu applies to high or low half as selected.
// RULE11: plain name is bits 31..16, low name is bits 15..0.
// RULE12: program counter not readable or writable by any move.
`timescale 1ns/1ps
module dcrw_regs
   import dcrw_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          rst,
   input  wire dcrw_req_type  req,
   output dcrw_rsp_type       rsp,
   output logic [ACC_W-1:0]   acc0_view,
   output logic [ACC_W-1:0]   acc1_view,
   output logic [WIDE_W-1:0]  prod_view,
   output logic [WIDE_W-1:0]  mult_view
);

   ////////////////////////////////////////////////////////////////////
   // helpers

   // sign-extend a 32-bit value to accumulator width
   function automatic logic [ACC_W-1:0] sext36(input logic [WIDE_W-1:0] v);
      sext36 = {{GUARD_W{v[WIDE_W-1]}}, v}; // [RULE9]
   endfunction : sext36

   // true for a selector that names an accumulator half
   function automatic logic is_acc_sel(input dcrw_sel_type s);
      is_acc_sel = (s == DCRW_SEL_ACC0_HI) || (s == DCRW_SEL_ACC0_LO) ||
                   (s == DCRW_SEL_ACC1_HI) || (s == DCRW_SEL_ACC1_LO);
   endfunction : is_acc_sel

   // selectors no move may read
   function automatic logic no_read(input dcrw_sel_type s);
      no_read = (s == DCRW_SEL_SER_CTRL) || (s == DCRW_SEL_SER_ADDR) ||
                (s == DCRW_SEL_TDM_CTRL) || (s == DCRW_SEL_ALT0) ||
                (s == DCRW_SEL_ALT1) || (s == DCRW_SEL_PC) ||
                (s == DCRW_SEL_NONE);
   endfunction : no_read

   // selectors no move may write
   function automatic logic no_write(input dcrw_sel_type s);
      no_write = (s == DCRW_SEL_ALT0) || (s == DCRW_SEL_ALT1) ||
                 (s == DCRW_SEL_PC) || (s == DCRW_SEL_NONE);
   endfunction : no_write

   ////////////////////////////////////////////////////////////////////
   // state

   logic [ACC_W-1:0]  acc_q  [2];
   logic [ACC_W-1:0]  acc_d  [2];
   logic [ACC_W-1:0]  alt_q  [2];
   logic [ACC_W-1:0]  alt_d  [2];
   logic [WIDE_W-1:0] prod_q;
   logic [WIDE_W-1:0] prod_d;
   logic [WIDE_W-1:0] mult_q;
   logic [WIDE_W-1:0] mult_d;
   logic [HALF_W-1:0] serc_q;
   logic [HALF_W-1:0] serc_d;
   logic [HALF_W-1:0] sera_q;
   logic [HALF_W-1:0] sera_d;
   logic [HALF_W-1:0] tdmc_q;
   logic [HALF_W-1:0] tdmc_d;
   dcrw_rsp_type      rsp_q;
   dcrw_rsp_type      rsp_d;

   logic [ACC_W-1:0]  alu_a;
   logic [ACC_W-1:0]  alu_b;
   dcrw_alu_type      alu_f;
   logic [ACC_W-1:0]  alu_y;
   logic [ACC_W-1:0]  src_acc_v;
   logic              dsel;
   logic [HALF_W-1:0] rd_val;
   logic signed [WIDE_W-1:0] mul_xs;
   logic signed [WIDE_W-1:0] mul_ys;
   logic [WIDE_W-1:0] full_prod;

   assign dsel = req.dst_acc;
   assign src_acc_v = acc_q[req.src_acc];
   // operands widened first so the product keeps all 32 bits
   assign mul_xs = WIDE_W'($signed(req.mul_x));
   assign mul_ys = WIDE_W'($signed(mult_q[WIDE_W-1:HI_LSB]));   // [RULE8]
   assign full_prod = mul_xs * mul_ys;

   dcrw_alu u_alu (
      .opa    (alu_a),
      .opb    (alu_b),
      .func   (alu_f),
      .result (alu_y)
   );

   ////////////////////////////////////////////////////////////////////
   // operand selection for the shared alu
   always_comb begin
      alu_a = src_acc_v;
      alu_b = '0;
      alu_f = DCRW_ALU_ADD;
      unique case (req.op)
         DCRW_OP_ADD_PROD: begin
            alu_b = sext36(prod_q);                  // [RULE5] [RULE9]
            alu_f = req.alu;
         end
         DCRW_OP_ADD_MULT: begin
            alu_b = sext36(mult_q);                  // [RULE8] [RULE9]
            alu_f = req.alu;
         end
         DCRW_OP_HIGH_INC: begin
            alu_a = {{GUARD_W{1'b0}}, {HALF_W{1'b0}},
                     src_acc_v[WIDE_W-1:HI_LSB]};   // [RULE5]
            alu_b = {{(ACC_W-HALF_W){1'b0}}, DCRW_ONE16};
         end
         DCRW_OP_IMM_ALU: begin
            alu_a = {{(ACC_W-HALF_W){1'b0}}, req.imm_high ?
                     src_acc_v[WIDE_W-1:HI_LSB] :
                     src_acc_v[HALF_W-1:0]};         // [RULE10]
            alu_b = {{(ACC_W-HALF_W){1'b0}}, req.data};
            alu_f = req.alu;
         end
         default: ;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // read value of a 16-bit move source
   always_comb begin
      rd_val = DCRW_ZERO16;
      unique case (req.src)
         DCRW_SEL_ACC0_HI: rd_val = acc_q[0][WIDE_W-1:HI_LSB]; // [RULE4]
         DCRW_SEL_ACC0_LO: rd_val = acc_q[0][HALF_W-1:0];
         DCRW_SEL_ACC1_HI: rd_val = acc_q[1][WIDE_W-1:HI_LSB];
         DCRW_SEL_ACC1_LO: rd_val = acc_q[1][HALF_W-1:0];
         DCRW_SEL_PROD_HI: rd_val = prod_q[WIDE_W-1:HI_LSB];   // [RULE6] [RULE11]
         DCRW_SEL_PROD_LO: rd_val = prod_q[HALF_W-1:0];        // [RULE11]
         DCRW_SEL_MULT_HI: rd_val = mult_q[WIDE_W-1:HI_LSB];   // [RULE7] [RULE11]
         DCRW_SEL_MULT_LO: rd_val = mult_q[HALF_W-1:0];        // [RULE11]
         default:          rd_val = DCRW_ZERO16;  // [RULE1] [RULE12]
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // next state of the register set
   always_comb begin
      logic [HALF_W-1:0] v;
      v      = DCRW_ZERO16;
      acc_d  = acc_q;
      alt_d  = alt_q;
      prod_d = prod_q;
      mult_d = mult_q;
      serc_d = serc_q;
      sera_d = sera_q;
      tdmc_d = tdmc_q;
      rsp_d  = '0;
      if (req.valid) begin
         rsp_d.valid = 1'b1;
         unique case (req.op)
            DCRW_OP_MOVE: begin
               // a source that cannot be read or a target that cannot
               // be written refuses the whole move
               if ((req.src != DCRW_SEL_NONE && no_read(req.src)) ||
                   no_write(req.dst)) begin
                  rsp_d.refused = 1'b1;             // [RULE1] [RULE2] [RULE12]
               end else begin
                  v = (req.src == DCRW_SEL_NONE) ? req.data : rd_val;
                  rsp_d.data = rd_val;
                  unique case (req.dst)
                     DCRW_SEL_ACC0_HI: acc_d[0][WIDE_W-1:HI_LSB] = v; // [RULE4]
                     DCRW_SEL_ACC0_LO: acc_d[0][HALF_W-1:0] = v;
                     DCRW_SEL_ACC1_HI: acc_d[1][WIDE_W-1:HI_LSB] = v;
                     DCRW_SEL_ACC1_LO: acc_d[1][HALF_W-1:0] = v;
                     DCRW_SEL_PROD_HI: prod_d[WIDE_W-1:HI_LSB] = v; // [RULE11]
                     DCRW_SEL_PROD_LO: prod_d[HALF_W-1:0] = v;
                     DCRW_SEL_MULT_HI: mult_d[WIDE_W-1:HI_LSB] = v;
                     DCRW_SEL_MULT_LO: mult_d[HALF_W-1:0] = v;
                     DCRW_SEL_SER_CTRL: serc_d = v;
                     DCRW_SEL_SER_ADDR: sera_d = v;
                     DCRW_SEL_TDM_CTRL: tdmc_d = v;
                     default: ;
                  endcase
               end
            end
            DCRW_OP_ACC_COPY:      acc_d[dsel] = src_acc_v;       // [RULE4]
            DCRW_OP_ACC_FROM_MULT: acc_d[dsel] = sext36(mult_q);  // [RULE4] [RULE9]
            DCRW_OP_PROD_TO_ACC:   acc_d[dsel] = sext36(prod_q);  // [RULE6]
            DCRW_OP_SPECIAL_MULT:  acc_d[dsel] = sext36(mult_q);  // [RULE7]
            DCRW_OP_ADD_PROD,
            DCRW_OP_ADD_MULT:      acc_d[dsel] = alu_y;           // [RULE5]
            DCRW_OP_HIGH_INC:
               acc_d[dsel][WIDE_W-1:HI_LSB] = alu_y[HALF_W-1:0];  // [RULE5]
            DCRW_OP_IMM_ALU: begin
               acc_d[dsel] = src_acc_v;
               if (req.imm_high)
                  acc_d[dsel][WIDE_W-1:HI_LSB] = alu_y[HALF_W-1:0]; // [RULE10]
               else
                  acc_d[dsel][HALF_W-1:0] = alu_y[HALF_W-1:0];
            end
            DCRW_OP_MULTIPLY:
               prod_d = full_prod[WIDE_W-1:0];                   // [RULE8]
            DCRW_OP_SWAP_ALT: begin
               acc_d[dsel] = alt_q[dsel];                         // [RULE2]
               alt_d[dsel] = acc_q[dsel];
            end
            default: rsp_d.refused = 1'b1;
         endcase
      end
   end

   // register the set
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         acc_q  <= '{default: '0};
         alt_q  <= '{default: '0};
         prod_q <= '0;
         mult_q <= '0;
         serc_q <= '0;
         sera_q <= '0;
         tdmc_q <= '0;
         rsp_q  <= '0;
      end else begin
         acc_q  <= acc_d;                                         // [RULE3]
         alt_q  <= alt_d;
         prod_q <= prod_d;
         mult_q <= mult_d;
         serc_q <= serc_d;
         sera_q <= sera_d;
         tdmc_q <= tdmc_d;
         rsp_q  <= rsp_d;
      end
   end

   assign rsp       = rsp_q;
   assign acc0_view = acc_q[0];
   assign acc1_view = acc_q[1];
   assign prod_view = prod_q;
   assign mult_view = mult_q;

   ////////////////////////////////////////////////////////////////////
   // checks

   a_wo_refused: assert property (@(posedge sys_clk) disable iff (rst)
      req.valid && req.op == DCRW_OP_MOVE && (req.src == DCRW_SEL_SER_CTRL ||
      req.src == DCRW_SEL_SER_ADDR || req.src == DCRW_SEL_TDM_CTRL)
      |=> rsp.refused) else $error("write-only read not refused"); // [RULE1]

   a_alt_guarded: assert property (@(posedge sys_clk) disable iff (rst)
      !(req.valid && req.op == DCRW_OP_SWAP_ALT) |=> $stable(alt_q[0]) &&
      $stable(alt_q[1])) else $error("alternate changed without swap"); // [RULE2]

   a_copy_full: assert property (@(posedge sys_clk) disable iff (rst)
      req.valid && req.op == DCRW_OP_ACC_COPY && req.dst_acc != req.src_acc
      |=> acc_q[$past(req.dst_acc)] == $past(src_acc_v))
      else $error("accumulator copy not full width"); // [RULE4]

   a_move_half: assert property (@(posedge sys_clk) disable iff (rst)
      req.valid && req.op == DCRW_OP_MOVE && req.src == DCRW_SEL_NONE &&
      req.dst == DCRW_SEL_ACC0_HI |=> acc_q[0][HALF_W-1:0] ==
      $past(acc_q[0][HALF_W-1:0]) && acc_q[0][WIDE_W-1:HI_LSB] == $past(req.data))
      else $error("16-bit move disturbed other bits"); // [RULE4]

   a_hinc_half: assert property (@(posedge sys_clk) disable iff (rst)
      req.valid && req.op == DCRW_OP_HIGH_INC && !req.dst_acc |=>
      acc_q[0][HALF_W-1:0] == $past(acc_q[0][HALF_W-1:0]) &&
      acc_q[0][ACC_W-1:WIDE_W] == $past(acc_q[0][ACC_W-1:WIDE_W]))
      else $error("high increment leaked out of 16 bits"); // [RULE5]

   a_prod_sext: assert property (@(posedge sys_clk) disable iff (rst)
      req.valid && req.op == DCRW_OP_PROD_TO_ACC |=>
      acc_q[$past(req.dst_acc)] == {{GUARD_W{$past(prod_q[WIDE_W-1])}},
      $past(prod_q)}) else $error("product not sign extended"); // [RULE6]

   a_mult_sext: assert property (@(posedge sys_clk) disable iff (rst)
      req.valid && req.op == DCRW_OP_SPECIAL_MULT |=>
      acc_q[$past(req.dst_acc)][ACC_W-1:WIDE_W] ==
      {GUARD_W{$past(mult_q[WIDE_W-1])}}) else $error("mult not extended"); // [RULE7]

   a_mul_upper: assert property (@(posedge sys_clk) disable iff (rst)
      req.valid && req.op == DCRW_OP_MULTIPLY |=> $signed(prod_q) ==
      $signed($past(req.mul_x)) * $signed($past(mult_q[WIDE_W-1:HI_LSB])))
      else $error("multiply wrong"); // [RULE8]

   a_imm_low: assert property (@(posedge sys_clk) disable iff (rst)
      req.valid && req.op == DCRW_OP_IMM_ALU && !req.imm_high |=>
      acc_q[$past(req.dst_acc)][ACC_W-1:HI_LSB] ==
      $past(src_acc_v[ACC_W-1:HI_LSB])) else $error("imm hit high half"); // [RULE10]

   a_low_name: assert property (@(posedge sys_clk) disable iff (rst)
      req.valid && req.op == DCRW_OP_MOVE && req.src == DCRW_SEL_PROD_LO &&
      !no_write(req.dst) |=> rsp.data == $past(prod_q[HALF_W-1:0]))
      else $error("low name wrong bits"); // [RULE11]

   a_pc_blocked: assert property (@(posedge sys_clk) disable iff (rst)
      req.valid && req.op == DCRW_OP_MOVE && (req.src == DCRW_SEL_PC ||
      req.dst == DCRW_SEL_PC) |=> rsp.refused) else $error("pc reached"); // [RULE12]

   c_swap: cover property (@(posedge sys_clk) disable iff (rst)
      req.valid && req.op == DCRW_OP_SWAP_ALT);
   c_imm_high: cover property (@(posedge sys_clk) disable iff (rst)
      req.valid && req.op == DCRW_OP_IMM_ALU && req.imm_high);
   c_mac: cover property (@(posedge sys_clk) disable iff (rst)
      req.valid && req.op == DCRW_OP_MULTIPLY ##1
      req.valid && req.op == DCRW_OP_ADD_PROD);
   c_refuse: cover property (@(posedge sys_clk) disable iff (rst)
      rsp.refused);

endmodule : dcrw_regs

// *** inc/dcrw_pkg.sv ***
// dcrw_pkg: widths, register selectors, operation codes and carriers
// for the core data register set.
// assumes: the decoder names registers and operations by these codes.
package dcrw_pkg;

   localparam int ACC_W  = 36;
   localparam int WIDE_W = 32;
   localparam int HALF_W = 16;
   localparam int HI_LSB = 16;
   localparam int GUARD_W = ACC_W - WIDE_W;

   // register selectors seen by data moves
   typedef enum logic [3:0] {
      DCRW_SEL_NONE,
      DCRW_SEL_ACC0_HI,
      DCRW_SEL_ACC0_LO,
      DCRW_SEL_ACC1_HI,
      DCRW_SEL_ACC1_LO,
      DCRW_SEL_PROD_HI,
      DCRW_SEL_PROD_LO,
      DCRW_SEL_MULT_HI,
      DCRW_SEL_MULT_LO,
      DCRW_SEL_SER_CTRL,
      DCRW_SEL_SER_ADDR,
      DCRW_SEL_TDM_CTRL,
      DCRW_SEL_ALT0,
      DCRW_SEL_ALT1,
      DCRW_SEL_PC
   } dcrw_sel_type;

   // datapath operations
   typedef enum logic [3:0] {
      DCRW_OP_NOP,
      DCRW_OP_MOVE,
      DCRW_OP_ACC_COPY,
      DCRW_OP_ACC_FROM_MULT,
      DCRW_OP_PROD_TO_ACC,
      DCRW_OP_SPECIAL_MULT,
      DCRW_OP_ADD_PROD,
      DCRW_OP_ADD_MULT,
      DCRW_OP_HIGH_INC,
      DCRW_OP_IMM_ALU,
      DCRW_OP_MULTIPLY,
      DCRW_OP_SWAP_ALT
   } dcrw_op_type;

   typedef enum logic [1:0] {
      DCRW_ALU_ADD,
      DCRW_ALU_SUB,
      DCRW_ALU_AND,
      DCRW_ALU_OR
   } dcrw_alu_type;

   // one request from the decoder
   typedef struct packed {
      logic                valid;
      dcrw_op_type         op;
      dcrw_sel_type        dst;
      dcrw_sel_type        src;
      logic                dst_acc;
      logic                src_acc;
      logic                imm_high;
      dcrw_alu_type        alu;
      logic [HALF_W-1:0]   data;
      logic [HALF_W-1:0]   mul_x;
   } dcrw_req_type;

   // answer to the decoder
   typedef struct packed {
      logic                valid;
      logic                refused;
      logic [HALF_W-1:0]   data;
   } dcrw_rsp_type;

   localparam logic [HALF_W-1:0] DCRW_ZERO16 = 16'h0000;
   localparam logic [HALF_W-1:0] DCRW_ONE16  = 16'h0001;

endpackage : dcrw_pkg

// *** src/dcrw_alu.sv ***
// dcrw_alu: 36-bit accumulator arithmetic; 16-bit half operations are zero-extended by the caller.
// assumes: operands already aligned by the caller, 32-bit values sign extended and 16-bit halves zero-extended.
`timescale 1ns/1ps
module dcrw_alu
   import dcrw_pkg::*;
(
   input  wire logic [ACC_W-1:0] opa,
   input  wire logic [ACC_W-1:0] opb,
   input  wire dcrw_alu_type     func,
   output logic      [ACC_W-1:0] result
);

   // combine two operands
   always_comb begin
      unique case (func)
         DCRW_ALU_ADD: result = opa + opb;
         DCRW_ALU_SUB: result = opa - opb;
         DCRW_ALU_AND: result = opa & opb;
         DCRW_ALU_OR:  result = opa | opb;
      endcase
   end

endmodule : dcrw_alu

// *** tb/dcrw_decoder_model.sv ***
// dcrw_decoder_model: stands in for the instruction decoder, one
// request at a time, and takes the registered answer.
// assumes: requests change on the falling edge of sys_clk.
`timescale 1ns/1ps
module dcrw_decoder_model
   import dcrw_pkg::*;
(
   input  wire logic          sys_clk,
   output dcrw_req_type       req,
   input  wire dcrw_rsp_type  rsp
);
   ////////////////////////////////////////////////////////////////////
   // idle: valid low, operands scrambled so nothing leans on them
   initial begin
      dcrw_req_type idle;
      idle = '0;
      idle.data = 16'h5a5a;
      req = idle;
   end

   // request held over one rising edge, answer taken in its cycle
   task automatic send(input dcrw_req_type r, output dcrw_rsp_type a);
      dcrw_req_type idle;
      @(negedge sys_clk);
      req = r;
      @(negedge sys_clk);
      a = rsp;
      idle = r;
      idle.valid = 1'b0;
      idle.data = ~r.data;
      idle.mul_x = ~r.mul_x;
      req = idle;
   endtask : send
endmodule : dcrw_decoder_model

// *** tb/dcrw_regs_tb.sv ***
// dcrw_regs_tb: self-checking bench for the data register set.
// assumes: the decoder model drives req; views are compared directly.
`timescale 1ns/1ps
module dcrw_regs_tb;
   import dcrw_pkg::*;
   logic               sys_clk;
   logic               rst;
   dcrw_req_type       req;
   dcrw_rsp_type       rsp;
   logic [ACC_W-1:0]   acc0_view;
   logic [ACC_W-1:0]   acc1_view;
   logic [WIDE_W-1:0]  prod_view;
   logic [WIDE_W-1:0]  mult_view;
   int                 failures;
   int                 tests_run;
   dcrw_req_type       r;
   dcrw_rsp_type       got;

   ////////////////////////////////////////////////////////////////////
   // clock, design and decoder model
   initial sys_clk = 1'b0;
   always #4 sys_clk = ~sys_clk;

   dcrw_regs dut_u (.sys_clk(sys_clk), .rst(rst), .req(req), .rsp(rsp),
      .acc0_view(acc0_view), .acc1_view(acc1_view),
      .prod_view(prod_view), .mult_view(mult_view));
   dcrw_decoder_model dec_u (.sys_clk(sys_clk), .req(req), .rsp(rsp));

   ////////////////////////////////////////////////////////////////////
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude();
      $display("counts: compares=%0d mismatches=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   // one request; other fields taken from r as last set
   task automatic go(input dcrw_op_type op, input dcrw_sel_type dst,
                     input dcrw_sel_type src, input logic [15:0] d);
      r.valid = 1'b1;
      r.op = op;
      r.dst = dst;
      r.src = src;
      r.data = d;
      dec_u.send(r, got);
      check(got.valid, 1'b1);
   endtask : go

   ////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check(acc0_view, 36'h0);
      check(acc1_view, 36'h0);
      check({prod_view, mult_view}, 64'h0);
      check(rsp, '0);
      $display("test reset done");
   endtask : t_reset

   // half writes land in the named half, reads give the named half
   task automatic t_moves();
      dcrw_sel_type      s[5];
      logic [15:0]       e[5];
      s = '{DCRW_SEL_PROD_HI, DCRW_SEL_PROD_LO, DCRW_SEL_MULT_HI,
            DCRW_SEL_MULT_LO, DCRW_SEL_ACC0_LO};
      e = '{16'hc3a5, 16'h1234, 16'hfffe, 16'h0003, 16'h7ffe};
      go(DCRW_OP_MOVE, DCRW_SEL_ACC0_HI, DCRW_SEL_NONE, 16'h8001);
      go(DCRW_OP_MOVE, DCRW_SEL_ACC0_LO, DCRW_SEL_NONE, 16'h7ffe);
      check(acc0_view, 36'h0_8001_7ffe);
      go(DCRW_OP_MOVE, DCRW_SEL_PROD_HI, DCRW_SEL_NONE, 16'hc3a5);
      go(DCRW_OP_MOVE, DCRW_SEL_PROD_LO, DCRW_SEL_NONE, 16'h1234);
      go(DCRW_OP_MOVE, DCRW_SEL_MULT_HI, DCRW_SEL_NONE, 16'hfffe);
      go(DCRW_OP_MOVE, DCRW_SEL_MULT_LO, DCRW_SEL_NONE, 16'h0003);
      check({prod_view, mult_view}, 64'hc3a5_1234_fffe_0003);
      for (int i = 0; i < 5; i++) begin
         go(DCRW_OP_MOVE, DCRW_SEL_SER_CTRL, s[i], 16'h0);
         check(got.data, e[i]);
      end
      $display("test moves done");
   endtask : t_moves

   // write-only, alternate and counter places refuse data moves
   task automatic t_refuse();
      dcrw_sel_type      s[6];
      s = '{DCRW_SEL_SER_CTRL, DCRW_SEL_SER_ADDR, DCRW_SEL_TDM_CTRL,
            DCRW_SEL_ALT0, DCRW_SEL_ALT1, DCRW_SEL_PC};
      for (int i = 0; i < 6; i++) begin
         go(DCRW_OP_MOVE, DCRW_SEL_ACC1_LO, s[i], 16'h0);
         check(got.refused, 1'b1);
      end
      go(DCRW_OP_MOVE, DCRW_SEL_ALT0, DCRW_SEL_NONE, 16'h1111);
      check(got.refused, 1'b1);
      go(DCRW_OP_MOVE, DCRW_SEL_PC, DCRW_SEL_NONE, 16'h2222);
      check(got.refused, 1'b1);
      check(acc1_view, 36'h0);
      $display("test refuse done");
   endtask : t_refuse

   // full-width moves into accumulators, with sign extension
   task automatic t_wide();
      r.dst_acc = 1'b0;
      go(DCRW_OP_SPECIAL_MULT, DCRW_SEL_NONE, DCRW_SEL_NONE, 16'h0);
      check(acc0_view, 36'hf_fffe_0003);
      r.dst_acc = 1'b1;
      r.src_acc = 1'b0;
      go(DCRW_OP_ACC_COPY, DCRW_SEL_NONE, DCRW_SEL_NONE, 16'h0);
      check(acc1_view, 36'hf_fffe_0003);
      go(DCRW_OP_PROD_TO_ACC, DCRW_SEL_NONE, DCRW_SEL_NONE, 16'h0);
      check(acc1_view, 36'hf_c3a5_1234);
      go(DCRW_OP_MOVE, DCRW_SEL_MULT_HI, DCRW_SEL_NONE, 16'h4000);
      r.dst_acc = 1'b0;
      go(DCRW_OP_ACC_FROM_MULT, DCRW_SEL_NONE, DCRW_SEL_NONE, 16'h0);
      check(acc0_view, 36'h0_4000_0003);
      $display("test wide done");
   endtask : t_wide

   // 36-bit sums, 16-bit increment and immediate on either half
   task automatic t_arith();
      r.dst_acc = 1'b0;
      r.src_acc = 1'b0;
      r.alu = DCRW_ALU_ADD;
      go(DCRW_OP_ADD_PROD, DCRW_SEL_NONE, DCRW_SEL_NONE, 16'h0);
      check(acc0_view, 36'h0_03a5_1237);
      r.dst_acc = 1'b1;
      r.src_acc = 1'b1;
      r.alu = DCRW_ALU_SUB;
      go(DCRW_OP_ADD_MULT, DCRW_SEL_NONE, DCRW_SEL_NONE, 16'h0);
      check(acc1_view, 36'hf_83a5_1231);
      r.dst_acc = 1'b0;
      r.src_acc = 1'b0;
      go(DCRW_OP_MOVE, DCRW_SEL_ACC0_HI, DCRW_SEL_NONE, 16'hffff);
      go(DCRW_OP_HIGH_INC, DCRW_SEL_NONE, DCRW_SEL_NONE, 16'h0);
      check(acc0_view, 36'h0_0000_1237);
      r.imm_high = 1'b0;
      r.alu = DCRW_ALU_ADD;
      go(DCRW_OP_IMM_ALU, DCRW_SEL_NONE, DCRW_SEL_NONE, 16'hffff);
      check(acc0_view, 36'h0_0000_1236);
      r.imm_high = 1'b1;
      r.alu = DCRW_ALU_OR;
      go(DCRW_OP_IMM_ALU, DCRW_SEL_NONE, DCRW_SEL_NONE, 16'h8000);
      check(acc0_view, 36'h0_8000_1236);
      r.imm_high = 1'b0;
      r.alu = DCRW_ALU_AND;
      go(DCRW_OP_IMM_ALU, DCRW_SEL_NONE, DCRW_SEL_NONE, 16'h00ff);
      check(acc0_view, 36'h0_8000_0036);
      r.imm_high = 1'b1;
      r.alu = DCRW_ALU_SUB;
      go(DCRW_OP_IMM_ALU, DCRW_SEL_NONE, DCRW_SEL_NONE, 16'h0001);
      check(acc0_view, 36'h0_7fff_0036);
      $display("test arith done");
   endtask : t_arith

   // plain multiply uses only the upper half of the multiplier input
   task automatic t_mult();
      r.mul_x = 16'h0003;
      go(DCRW_OP_MULTIPLY, DCRW_SEL_NONE, DCRW_SEL_NONE, 16'h0);
      check(prod_view, 32'h0000_c000);
      go(DCRW_OP_MOVE, DCRW_SEL_MULT_HI, DCRW_SEL_NONE, 16'hfffe);
      r.mul_x = 16'h0005;
      go(DCRW_OP_MULTIPLY, DCRW_SEL_NONE, DCRW_SEL_NONE, 16'h0);
      check(prod_view, 32'hffff_fff6);
      $display("test mult done");
   endtask : t_mult

   // swap is the one way in and out of the alternates
   task automatic t_swap();
      r.dst_acc = 1'b0;
      go(DCRW_OP_SWAP_ALT, DCRW_SEL_NONE, DCRW_SEL_NONE, 16'h0);
      check(got.refused, 1'b0);
      check(acc0_view, 36'h0);
      go(DCRW_OP_NOP, DCRW_SEL_NONE, DCRW_SEL_NONE, 16'h0);
      check(got.refused, 1'b1);
      go(DCRW_OP_SWAP_ALT, DCRW_SEL_NONE, DCRW_SEL_NONE, 16'h0);
      check(acc0_view, 36'h0_7fff_0036);
      check(acc1_view, 36'hf_83a5_1231);
      $display("test swap done");
   endtask : t_swap

   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      failures = 0;
      tests_run = 0;
      r = '0;
      rst = 1'b1;
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      t_reset();
      t_moves();
      t_refuse();
      t_wide();
      t_arith();
      t_mult();
      t_swap();
      conclude();
   end

   // watchdog: the whole run needs well under 200 cycles
   initial begin
      #40000;
      failures++;
      conclude();
   end
endmodule : dcrw_regs_tb
